// ---- mvi_cpu_model.sv ----
`timescale 1ns/100ps
module mvi_cpu_model
  import mvi_pkg::*;
(
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic cpu_clock_run,
  input  wire logic halt_cmd,
  output logic      instr_done,
  output logic      halt_enter
);
  logic [1:0] phase_r;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      phase_r    <= 2'h0;
      instr_done <= 1'b0;
      halt_enter <= 1'b0;
    end else begin
      // stopped core retires nothing, so no instruction end while halted
      phase_r    <= cpu_clock_run ? phase_r + 2'h1 : phase_r;
      instr_done <= cpu_clock_run && phase_r == 2'h3;
      halt_enter <= halt_cmd && !halt_enter;
    end
  end
endmodule // mvi_cpu_model

// ---- mvi_edge_detect.sv ----
`timescale 1ns/100ps
module mvi_edge_detect
  import mvi_pkg::*;
#(
  parameter int W    = 1,
  parameter bit RISE = 1'b1,
  parameter bit FALL = 1'b1
) (
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic [W-1:0] level,
  input  wire logic [W-1:0] enable,
  output logic      [W-1:0] hit
);
  logic [W-1:0] prev_r;
  logic [W-1:0] prev_nxt;
  logic         armed_r;
  logic         armed_nxt;

  // first cycle after reset only samples, so a high pin is no edge
  always_comb begin
    prev_nxt  = level;
    armed_nxt = 1'b1;
    hit = {W{armed_r}} & enable &
          (({W{RISE}} & level & ~prev_r) | ({W{FALL}} & ~level & prev_r));
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      prev_r  <= '0;
      armed_r <= 1'b0;
    end else begin
      prev_r  <= prev_nxt;
      armed_r <= armed_nxt;
    end
  end
endmodule // mvi_edge_detect

// ---- mvi_interrupt_unit.sv ----
`timescale 1ns/100ps
module mvi_interrupt_unit
  import mvi_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  // axi4-lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // event sources
  input  wire logic        timer_2hz,
  input  wire logic        timer_8hz,
  input  wire logic        timer_32hz,
  input  wire logic        stopwatch_1hz,
  input  wire logic        stopwatch_10hz,
  input  wire logic        serial_xfer_done,
  input  wire logic [3:0]  group0_input_pins,
  input  wire logic        group1_input_pin,
  input  wire logic [3:0]  group2_input_pins,
  // cpu core sequencer
  input  wire logic        irq_globally_on,
  input  wire logic        irq_globally_off,
  input  wire logic        instr_done,
  input  wire logic        halt_enter,
  output logic             irq_enable,
  output logic             irq_request,
  output logic             entry_busy,
  output logic             pc_push,
  output logic             pc_load,
  output logic [3:0]       vector_low,
  output logic             cpu_clock_run,
  output logic             heavy_load_protect_mode,
  output logic             lcd_drive_static_select
);

  // software-visible storage
  logic [3:0] g0_compare_r;
  logic [3:0] g0_compare_nxt;
  logic [3:0] g0_mask_r;
  logic [3:0] g0_mask_nxt;
  logic [1:0] sw_mask_r;
  logic [1:0] sw_mask_nxt;
  logic       heavy_load_r;
  logic       heavy_load_nxt;
  logic       g1_mask_r;
  logic       g1_mask_nxt;
  logic       g1_compare_r;
  logic       g1_compare_nxt;
  logic [2:0] timer_mask_r;
  logic [2:0] timer_mask_nxt;
  logic       lcd_static_r;
  logic       lcd_static_nxt;
  logic [3:0] ser_ctrl_r;
  logic [3:0] ser_ctrl_nxt;
  logic [3:0] g2_mask_r;
  logic [3:0] g2_mask_nxt;

  // bus state
  logic        aw_held_r;
  logic        aw_held_nxt;
  logic [9:0]  aw_idx_r;
  logic [9:0]  aw_idx_nxt;
  logic        w_held_r;
  logic        w_held_nxt;
  logic [3:0]  wdata_r;
  logic [3:0]  wdata_nxt;
  logic        wlane_r;
  logic        wlane_nxt;
  logic        bvalid_r;
  logic        bvalid_nxt;
  logic [1:0]  bresp_r;
  logic [1:0]  bresp_nxt;
  logic        arready_r;
  logic        arready_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0]  rresp_r;
  logic [1:0]  rresp_nxt;

  // entry sequencer state
  mvi_state_t  state_r;
  mvi_state_t  state_nxt;
  logic [3:0]  cnt_r;
  logic [3:0]  cnt_nxt;
  logic        ei_r;
  logic        ei_nxt;
  logic        halted_r;
  logic        halted_nxt;
  logic        req_r;
  logic        req_nxt;
  logic        push_r;
  logic        push_nxt;
  logic        load_r;
  logic        load_nxt;
  logic [3:0]  vec_r;
  logic [3:0]  vec_nxt;

  // combinational helpers
  logic [4:0]             tick_fall;
  logic [3:0]             g0_hit;
  logic                   g1_hit;
  logic [3:0]             g2_hit;
  mvi_flags_t             fl;
  mvi_flags_t             fl_set;
  mvi_flags_t             fl_clr;
  logic [MVI_NFLAGS-1:0]  fl_vec;
  logic                   wr_fire;
  logic                   rd_fire;
  logic [9:0]             ar_idx;
  logic                   rd_hit;
  logic [3:0]             rd_val;
  logic                   wr_hit;
  logic [3:0]             vec_now;

  mvi_edge_detect #(.W(5), .RISE(1'b0), .FALL(1'b1)) u_ticks (
    .clock  (clock),
    .resetn (resetn),
    .level  ({timer_2hz, timer_8hz, timer_32hz, stopwatch_1hz, stopwatch_10hz}),
    .enable (5'h1f),
    .hit    (tick_fall)
  );

  mvi_edge_detect #(.W(4), .RISE(1'b1), .FALL(1'b1)) u_group0 (
    .clock  (clock),
    .resetn (resetn),
    .level  (group0_input_pins),
    .enable (g0_mask_r),
    .hit    (g0_hit)
  );

  mvi_edge_detect #(.W(1), .RISE(1'b1), .FALL(1'b1)) u_group1 (
    .clock  (clock),
    .resetn (resetn),
    .level  (group1_input_pin),
    .enable (g1_mask_r),
    .hit    (g1_hit)
  );

  mvi_edge_detect #(.W(4), .RISE(1'b1), .FALL(1'b0)) u_group2 (
    .clock  (clock),
    .resetn (resetn),
    .level  (group2_input_pins),
    .enable (g2_mask_r),
    .hit    (g2_hit)
  );

  mvi_sticky_flags #(.W(MVI_NFLAGS)) u_flags (
    .clock  (clock),
    .resetn (resetn),
    .set    (fl_set),
    .clr    (fl_clr),
    .flags  (fl_vec)
  );

  assign fl = mvi_flags_t'(fl_vec);

  // flag sources and read-clear
  always_comb begin
    fl_set = '0;
    fl_set.timer_slow_tick_flag  = tick_fall[4];
    fl_set.timer_mid_tick_flag   = tick_fall[3];
    fl_set.timer_fast_tick_flag  = tick_fall[2];
    fl_set.stopwatch_second_flag = tick_fall[1];
    fl_set.stopwatch_tenth_flag  = tick_fall[0];
    fl_set.serial_done_flag      = serial_xfer_done;
    fl_set.port_group0_flag      = |g0_hit;
    fl_set.port_group1_flag      = g1_hit;
    fl_set.port_group2_flag      = |g2_hit;
    fl_clr = '0;
    if (rd_fire) begin
      case (ar_idx)
        MVI_IDX_TIMER_FLAGS: begin
          fl_clr.timer_slow_tick_flag = 1'b1;
          fl_clr.timer_mid_tick_flag  = 1'b1;
          fl_clr.timer_fast_tick_flag = 1'b1;
        end
        MVI_IDX_PORT_SW_FLAGS: begin
          fl_clr.port_group1_flag      = 1'b1;
          fl_clr.port_group0_flag      = 1'b1;
          fl_clr.stopwatch_second_flag = 1'b1;
          fl_clr.stopwatch_tenth_flag  = 1'b1;
        end
        MVI_IDX_SER_G2_FLAGS: begin
          fl_clr.port_group2_flag = 1'b1;
          fl_clr.serial_done_flag = 1'b1;
        end
        default: begin
          fl_clr = '0;
        end
      endcase
    end
  end

  // read decode; bits above the low nibble read as zero
  always_comb begin
    ar_idx = s_axi_araddr[11:2];
    rd_hit = 1'b1;
    rd_val = 4'h0;
    case (ar_idx)
      MVI_IDX_G0_COMPARE:    rd_val = g0_compare_r;
      MVI_IDX_G0_MASK:       rd_val = g0_mask_r;
      MVI_IDX_LOAD_SW_MASK:  rd_val = {heavy_load_r, 1'b0, sw_mask_r};
      MVI_IDX_SER_G1_CTRL:   rd_val = {1'b0, g1_mask_r, g1_compare_r, group1_input_pin};
      MVI_IDX_TIMER_MASK:    rd_val = {lcd_static_r, timer_mask_r};
      MVI_IDX_TIMER_FLAGS:   rd_val = {1'b0, fl.timer_slow_tick_flag,
                                       fl.timer_mid_tick_flag, fl.timer_fast_tick_flag};
      MVI_IDX_PORT_SW_FLAGS: rd_val = {fl.port_group1_flag, fl.port_group0_flag,
                                       fl.stopwatch_second_flag, fl.stopwatch_tenth_flag};
      MVI_IDX_SER_CTRL_MASK: rd_val = ser_ctrl_r;
      MVI_IDX_SER_G2_FLAGS:  rd_val = {2'h0, fl.port_group2_flag, fl.serial_done_flag};
      MVI_IDX_G2_MASK:       rd_val = g2_mask_r;
      default:               rd_hit = 1'b0;
    endcase
  end

  // axi4-lite handshakes: one read in flight; a second write is held while the first response waits
  always_comb begin
    aw_held_nxt = aw_held_r;
    aw_idx_nxt  = aw_idx_r;
    w_held_nxt  = w_held_r;
    wdata_nxt   = wdata_r;
    wlane_nxt   = wlane_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (s_axi_awvalid && !aw_held_r) begin
      aw_held_nxt = 1'b1;
      aw_idx_nxt  = s_axi_awaddr[11:2];
    end
    if (s_axi_wvalid && !w_held_r) begin
      w_held_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata[3:0];
      wlane_nxt  = s_axi_wstrb[0];
    end
    wr_fire = aw_held_r && w_held_r && !bvalid_r;
    if (wr_fire) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = wr_hit ? MVI_RESP_OKAY : MVI_RESP_SLVERR;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    rd_fire = s_axi_arvalid && arready_r;
    if (rd_fire) begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rdata_nxt   = {28'h0000000, rd_val};
      rresp_nxt   = rd_hit ? MVI_RESP_OKAY : MVI_RESP_SLVERR;
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  // register writes; flag registers ignore writes
  always_comb begin
    g0_compare_nxt = g0_compare_r;
    g0_mask_nxt    = g0_mask_r;
    sw_mask_nxt    = sw_mask_r;
    heavy_load_nxt = heavy_load_r;
    g1_mask_nxt    = g1_mask_r;
    g1_compare_nxt = g1_compare_r;
    timer_mask_nxt = timer_mask_r;
    lcd_static_nxt = lcd_static_r;
    ser_ctrl_nxt   = ser_ctrl_r;
    g2_mask_nxt    = g2_mask_r;
    wr_hit         = 1'b1;
    case (aw_idx_r)
      MVI_IDX_G0_COMPARE, MVI_IDX_G0_MASK, MVI_IDX_LOAD_SW_MASK,
      MVI_IDX_SER_G1_CTRL, MVI_IDX_TIMER_MASK, MVI_IDX_SER_CTRL_MASK,
      MVI_IDX_G2_MASK, MVI_IDX_TIMER_FLAGS, MVI_IDX_PORT_SW_FLAGS,
      MVI_IDX_SER_G2_FLAGS: wr_hit = 1'b1;
      default:              wr_hit = 1'b0;
    endcase
    if (aw_held_r && w_held_r && !bvalid_r && wlane_r) begin
      case (aw_idx_r)
        MVI_IDX_G0_COMPARE:   g0_compare_nxt = wdata_r;
        MVI_IDX_G0_MASK:      g0_mask_nxt    = wdata_r;
        MVI_IDX_LOAD_SW_MASK: begin
          heavy_load_nxt = wdata_r[MVI_POS_HEAVY_LOAD];
          sw_mask_nxt    = wdata_r[1:0];
        end
        MVI_IDX_SER_G1_CTRL:  begin
          g1_mask_nxt    = wdata_r[MVI_POS_G1_MASK];
          g1_compare_nxt = wdata_r[MVI_POS_G1_COMPARE];
        end
        MVI_IDX_TIMER_MASK:   begin
          lcd_static_nxt = wdata_r[MVI_POS_LCD_STATIC];
          timer_mask_nxt = wdata_r[2:0];
        end
        MVI_IDX_SER_CTRL_MASK: ser_ctrl_nxt = wdata_r;
        MVI_IDX_G2_MASK:       g2_mask_nxt  = wdata_r;
        default:               g0_mask_nxt  = g0_mask_r;
      endcase
    end
  end

  // vector from pending enabled sources
  always_comb begin
    vec_now[3] = |({fl.stopwatch_second_flag, fl.stopwatch_tenth_flag} & sw_mask_r);
    vec_now[2] = |({fl.timer_slow_tick_flag, fl.timer_mid_tick_flag,
                    fl.timer_fast_tick_flag} & timer_mask_r);
    vec_now[1] = (fl.port_group0_flag & (|g0_mask_r)) |
                 (fl.port_group1_flag & g1_mask_r) |
                 (fl.port_group2_flag & (|g2_mask_r));
    vec_now[0] = fl.serial_done_flag & ser_ctrl_r[0];
  end

  // entry sequencer
  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    ei_nxt     = ei_r;
    halted_nxt = halted_r;
    vec_nxt    = vec_r;
    push_nxt   = 1'b0;
    load_nxt   = 1'b0;
    req_nxt    = ei_r && (|vec_now);
    if (irq_globally_on) begin
      ei_nxt = 1'b1;
    end
    if (irq_globally_off) begin
      ei_nxt = 1'b0;
    end
    if (halt_enter) begin
      halted_nxt = 1'b1;
    end
    case (state_r)
      MVI_IDLE: begin
        // halted cpu has no instruction to finish
        if (req_r && (instr_done || halted_r)) begin
          state_nxt  = MVI_ENTRY;
          cnt_nxt    = 4'h0;
          ei_nxt     = 1'b0;
          halted_nxt = 1'b0;
          vec_nxt    = vec_now;
          push_nxt   = 1'b1;
          req_nxt    = 1'b0;
        end
      end
      MVI_ENTRY: begin
        req_nxt = 1'b0;
        ei_nxt  = 1'b0;
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == MVI_ENTRY_LAST - 4'h1) begin
          load_nxt = 1'b1;
        end
        if (cnt_r == MVI_ENTRY_LAST) begin
          state_nxt = MVI_IDLE;
          cnt_nxt   = 4'h0;
        end
      end
      default: begin
        state_nxt = MVI_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      g0_compare_r <= MVI_RST_COMPARE;
      g0_mask_r    <= MVI_RST_MASK;
      sw_mask_r    <= MVI_RST_MASK[1:0];
      heavy_load_r <= MVI_RST_BIT;
      g1_mask_r    <= MVI_RST_BIT;
      g1_compare_r <= MVI_RST_BIT;
      timer_mask_r <= MVI_RST_MASK[2:0];
      lcd_static_r <= MVI_RST_BIT;
      ser_ctrl_r   <= MVI_RST_SER_CTRL;
      g2_mask_r    <= MVI_RST_MASK;
      aw_held_r    <= 1'b0;
      aw_idx_r     <= '0;
      w_held_r     <= 1'b0;
      wdata_r      <= '0;
      wlane_r      <= 1'b0;
      bvalid_r     <= 1'b0;
      bresp_r      <= MVI_RESP_OKAY;
      arready_r    <= 1'b0;
      rvalid_r     <= 1'b0;
      rdata_r      <= '0;
      rresp_r      <= MVI_RESP_OKAY;
      state_r      <= MVI_IDLE;
      cnt_r        <= 4'h0;
      ei_r         <= 1'b0;
      halted_r     <= 1'b0;
      req_r        <= 1'b0;
      push_r       <= 1'b0;
      load_r       <= 1'b0;
      vec_r        <= 4'h0;
    end else begin
      g0_compare_r <= g0_compare_nxt;
      g0_mask_r    <= g0_mask_nxt;
      sw_mask_r    <= sw_mask_nxt;
      heavy_load_r <= heavy_load_nxt;
      g1_mask_r    <= g1_mask_nxt;
      g1_compare_r <= g1_compare_nxt;
      timer_mask_r <= timer_mask_nxt;
      lcd_static_r <= lcd_static_nxt;
      ser_ctrl_r   <= ser_ctrl_nxt;
      g2_mask_r    <= g2_mask_nxt;
      aw_held_r    <= aw_held_nxt;
      aw_idx_r     <= aw_idx_nxt;
      w_held_r     <= w_held_nxt;
      wdata_r      <= wdata_nxt;
      wlane_r      <= wlane_nxt;
      bvalid_r     <= bvalid_nxt;
      bresp_r      <= bresp_nxt;
      arready_r    <= (arready_nxt || (!arready_r && !rvalid_r && !rd_fire)) && !rvalid_nxt;
      rvalid_r     <= rvalid_nxt;
      rdata_r      <= rdata_nxt;
      rresp_r      <= rresp_nxt;
      state_r      <= state_nxt;
      cnt_r        <= cnt_nxt;
      ei_r         <= ei_nxt;
      halted_r     <= halted_nxt;
      req_r        <= req_nxt;
      push_r       <= push_nxt;
      load_r       <= load_nxt;
      vec_r        <= vec_nxt;
    end
  end

  // all outputs straight from flops
  assign s_axi_awready           = !aw_held_r;
  assign s_axi_wready            = !w_held_r;
  assign s_axi_bvalid            = bvalid_r;
  assign s_axi_bresp             = bresp_r;
  assign s_axi_arready           = arready_r;
  assign s_axi_rvalid            = rvalid_r;
  assign s_axi_rdata             = rdata_r;
  assign s_axi_rresp             = rresp_r;
  assign irq_enable              = ei_r;
  assign irq_request             = req_r;
  assign entry_busy              = (state_r == MVI_ENTRY);
  assign pc_push                 = push_r;
  assign pc_load                 = load_r;
  assign vector_low              = vec_r;
  assign cpu_clock_run           = !halted_r;
  assign heavy_load_protect_mode = heavy_load_r;
  assign lcd_drive_static_select = lcd_static_r;

endmodule // mvi_interrupt_unit

// ---- mvi_interrupt_unit_chk.sv ----
`timescale 1ns/100ps
module mvi_interrupt_unit_chk
  import mvi_pkg::*;
(
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        irq_request,
  input wire logic        irq_enable,
  input wire logic        entry_busy,
  input wire logic        pc_push,
  input wire logic        pc_load,
  input wire logic [3:0]  vector_low,
  input wire logic        instr_done,
  input wire logic        cpu_clock_run,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // eleven cycles without a load, then the load in the twelfth
  sequence s_wait; (entry_busy && !pc_load)[*8] ##1 (entry_busy && !pc_load)[*3]; endsequence
  sequence s_load; entry_busy && pc_load ##1 !entry_busy; endsequence
  property p_req_gate; irq_request |-> $past(irq_enable); endproperty
  property p_busy_quiet; entry_busy |-> !irq_request; endproperty
  property p_entry_start;
    pc_push |-> $past(irq_request) && ($past(instr_done) || !$past(cpu_clock_run));
  endproperty
  property p_entry_len; pc_push |-> s_wait ##1 s_load; endproperty
  property p_entry_di; pc_push |-> !irq_enable && vector_low != 4'h0; endproperty
  property p_halt_wake; !cpu_clock_run && irq_request |=> cpu_clock_run && pc_push; endproperty
  property p_vec_hold; entry_busy && !pc_push |-> $stable(vector_low); endproperty
  property p_rd_clean;
    s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0 &&
                     (s_axi_rresp != MVI_RESP_SLVERR || s_axi_rdata == 32'h0);
  endproperty
  a_req_gate: assert property (p_req_gate) else $error("request while disabled");
  a_busy_quiet: assert property (p_busy_quiet) else $error("request during entry");
  a_entry_start: assert property (p_entry_start) else $error("entry mid instruction");
  a_entry_len: assert property (p_entry_len) else $error("entry length wrong");
  a_entry_di: assert property (p_entry_di) else $error("entry left enable on");
  a_halt_wake: assert property (p_halt_wake) else $error("halt not woken");
  a_vec_hold: assert property (p_vec_hold) else $error("vector moved in entry");
  a_rd_clean: assert property (p_rd_clean) else $error("read data upper bits set");
endmodule // mvi_interrupt_unit_chk

// ---- mvi_interrupt_unit_tb.sv ----
`timescale 1ns/100ps
module mvi_interrupt_unit_tb
  import mvi_pkg::*;
;
  logic        clock, resetn, halt_cmd;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, group0_input_pins, group2_input_pins, vector_low;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        timer_2hz, timer_8hz, timer_32hz, stopwatch_1hz, stopwatch_10hz;
  logic        serial_xfer_done, group1_input_pin, irq_globally_on, irq_globally_off;
  logic        instr_done, halt_enter, irq_enable, irq_request, entry_busy, pc_push, pc_load;
  logic        cpu_clock_run, heavy_load_protect_mode, lcd_drive_static_select;
  int          failures, checks;
  logic [9:0]  ix_a [10] = '{MVI_IDX_G0_COMPARE, MVI_IDX_G0_MASK, MVI_IDX_LOAD_SW_MASK,
    MVI_IDX_SER_G1_CTRL, MVI_IDX_TIMER_MASK, MVI_IDX_TIMER_FLAGS, MVI_IDX_PORT_SW_FLAGS,
    MVI_IDX_SER_CTRL_MASK, MVI_IDX_SER_G2_FLAGS, MVI_IDX_G2_MASK};
  logic [3:0]  rst_a [10] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'hc, 4'h0, 4'h0};
  // all ones written: reserved and status bits read back zero
  logic [3:0]  wr_a [10] = '{4'hf, 4'hf, 4'hb, 4'h6, 4'hf, 4'h0, 4'h0, 4'hf, 4'h0, 4'hf};

  mvi_interrupt_unit dut (.*);
  mvi_cpu_model cpu (.clock(clock), .resetn(resetn), .cpu_clock_run(cpu_clock_run),
    .halt_cmd(halt_cmd), .instr_done(instr_done), .halt_enter(halt_enter));

  task chk(input string nm, input logic [3:0] e, input logic [3:0] s);
    checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task settle;
    repeat (4) @(posedge clock);
  endtask
  task endt(input string t);
    $display("test %s finished, mismatches so far %0d", t, failures);
  endtask
  task automatic wr(input logic [9:0] ix, input logic [3:0] d,
                    input logic [1:0] er = MVI_RESP_OKAY);
    int n;
    n = 0;
    s_axi_awaddr  <= {ix, 2'b00};
    s_axi_wdata   <= {28'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    chk("bresp", {2'b10, er}, {s_axi_bvalid, 1'b0, s_axi_bresp});
  endtask
  task automatic rd(input logic [9:0] ix, input logic [3:0] e,
                    input logic [1:0] er = MVI_RESP_OKAY);
    int n;
    n = 0;
    s_axi_araddr  <= {ix, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    chk("rdata", e, s_axi_rdata[3:0]);
    chk("rresp", {2'b10, er}, {s_axi_rvalid, 1'b0, s_axi_rresp});
  endtask
  task automatic ent(input logic [3:0] v);
    int n;
    n = 0;
    while (pc_push !== 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    chk("vector", v, vector_low);
    chk("enable", 4'h0, {3'b0, irq_enable});
    n = 0;
    while (entry_busy === 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    chk("entry cycles", 4'hc, 4'(n));
    @(posedge clock);
  endtask
  task tally_and_finish;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    tally_and_finish;
  end
  initial begin
    {failures, checks, resetn, halt_cmd, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {timer_2hz, timer_8hz, timer_32hz, stopwatch_1hz, stopwatch_10hz, serial_xfer_done} = '0;
    {group0_input_pins, group1_input_pin, group2_input_pins} = '0;
    {irq_globally_on, irq_globally_off} = '0;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 10; i++) begin
      rd(ix_a[i], rst_a[i]);
      wr(ix_a[i], 4'hf);
      chk("outs", {2'b0, i == 2, i == 4},
          {2'b0, heavy_load_protect_mode, lcd_drive_static_select});
      rd(ix_a[i], wr_a[i]);
      wr(ix_a[i], 4'h0);
    end
    rd(10'h000, 4'h0, MVI_RESP_SLVERR);
    wr(10'h000, 4'hf, MVI_RESP_SLVERR);
    endt("registers");
    {timer_2hz, timer_8hz, timer_32hz, stopwatch_1hz, stopwatch_10hz} <= 5'h1f;
    settle;
    rd(MVI_IDX_TIMER_FLAGS, 4'h0);
    {timer_2hz, timer_8hz, timer_32hz, stopwatch_1hz, stopwatch_10hz} <= 5'h00;
    serial_xfer_done <= 1'b1;
    @(posedge clock);
    serial_xfer_done <= 1'b0;
    settle;
    rd(MVI_IDX_TIMER_FLAGS, 4'h7);
    rd(MVI_IDX_TIMER_FLAGS, 4'h0);
    rd(MVI_IDX_PORT_SW_FLAGS, 4'h3);
    rd(MVI_IDX_SER_G2_FLAGS, 4'h1);
    endt("events");
    group0_input_pins <= 4'hf;
    group1_input_pin  <= 1'b1;
    group2_input_pins <= 4'hf;
    settle;
    rd(MVI_IDX_PORT_SW_FLAGS, 4'h0);
    rd(MVI_IDX_SER_G2_FLAGS, 4'h0);
    wr(MVI_IDX_G0_MASK, 4'h2);
    wr(MVI_IDX_G2_MASK, 4'hf);
    wr(MVI_IDX_SER_G1_CTRL, 4'h4);
    group0_input_pins <= 4'he;
    settle;
    rd(MVI_IDX_PORT_SW_FLAGS, 4'h0);
    group0_input_pins <= 4'hc;
    group2_input_pins <= 4'h0;
    settle;
    rd(MVI_IDX_PORT_SW_FLAGS, 4'h4);
    rd(MVI_IDX_SER_G2_FLAGS, 4'h0);
    group2_input_pins <= 4'h4;
    group1_input_pin  <= 1'b0;
    settle;
    rd(MVI_IDX_SER_G2_FLAGS, 4'h2);
    rd(MVI_IDX_PORT_SW_FLAGS, 4'h8);
    wr(MVI_IDX_G0_MASK, 4'h0);
    wr(MVI_IDX_G2_MASK, 4'h0);
    wr(MVI_IDX_SER_G1_CTRL, 4'h0);
    endt("ports");
    wr(MVI_IDX_TIMER_MASK, 4'h4);
    wr(MVI_IDX_SER_CTRL_MASK, 4'h1);
    timer_2hz <= 1'b1;
    @(posedge clock);
    timer_2hz        <= 1'b0;
    serial_xfer_done <= 1'b1;
    @(posedge clock);
    serial_xfer_done <= 1'b0;
    settle;
    chk("request", 4'h0, {3'b0, irq_request});
    irq_globally_on  <= 1'b1;
    irq_globally_off <= 1'b1;
    @(posedge clock);
    irq_globally_on  <= 1'b0;
    irq_globally_off <= 1'b0;
    settle;
    chk("enable", 4'h0, {3'b0, irq_enable});
    irq_globally_on <= 1'b1;
    @(posedge clock);
    irq_globally_on <= 1'b0;
    ent(4'h5);
    rd(MVI_IDX_TIMER_FLAGS, 4'h4);
    rd(MVI_IDX_SER_G2_FLAGS, 4'h1);
    fork
      rd(MVI_IDX_SER_G2_FLAGS, 4'h0);
      begin
        serial_xfer_done <= 1'b1;
        @(posedge clock);
        serial_xfer_done <= 1'b0;
      end
    join
    rd(MVI_IDX_SER_G2_FLAGS, 4'h1);
    endt("entry");
    halt_cmd <= 1'b1;
    @(posedge clock);
    halt_cmd <= 1'b0;
    settle;
    chk("clock run", 4'h0, {3'b0, cpu_clock_run});
    wr(MVI_IDX_LOAD_SW_MASK, 4'h2);
    stopwatch_1hz <= 1'b1;
    @(posedge clock);
    stopwatch_1hz <= 1'b0;
    settle;
    irq_globally_on <= 1'b1;
    @(posedge clock);
    irq_globally_on <= 1'b0;
    ent(4'h8);
    chk("clock run", 4'h1, {3'b0, cpu_clock_run});
    rd(MVI_IDX_PORT_SW_FLAGS, 4'h2);
    endt("halt");
    tally_and_finish;
  end
endmodule // mvi_interrupt_unit_tb

bind mvi_interrupt_unit mvi_interrupt_unit_chk u_chk (.*);

// ---- mvi_pkg.sv ----
package mvi_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0] MVI_IDX_G0_COMPARE   = 10'h2e4;
  localparam logic [9:0] MVI_IDX_G0_MASK      = 10'h2e5;
  localparam logic [9:0] MVI_IDX_LOAD_SW_MASK = 10'h2e6;
  localparam logic [9:0] MVI_IDX_SER_G1_CTRL  = 10'h2e7;
  localparam logic [9:0] MVI_IDX_TIMER_MASK   = 10'h2e8;
  localparam logic [9:0] MVI_IDX_TIMER_FLAGS  = 10'h2e9;
  localparam logic [9:0] MVI_IDX_PORT_SW_FLAGS = 10'h2ea;
  localparam logic [9:0] MVI_IDX_SER_CTRL_MASK = 10'h2f2;
  localparam logic [9:0] MVI_IDX_SER_G2_FLAGS = 10'h2f3;
  localparam logic [9:0] MVI_IDX_G2_MASK      = 10'h2f5;

  // reset values
  localparam logic [3:0] MVI_RST_MASK     = 4'h0;
  localparam logic [3:0] MVI_RST_COMPARE  = 4'h0;
  localparam logic [3:0] MVI_RST_SER_CTRL = 4'hc;
  localparam logic       MVI_RST_BIT      = 1'b0;

  // field positions inside the mixed registers
  localparam int MVI_POS_HEAVY_LOAD = 3;
  localparam int MVI_POS_G1_MASK    = 2;
  localparam int MVI_POS_G1_COMPARE = 1;
  localparam int MVI_POS_G1_PIN     = 0;
  localparam int MVI_POS_LCD_STATIC = 3;

  // interrupt entry: save pc plus vector load
  localparam int         MVI_ENTRY_CYCLES = 12;
  localparam logic [3:0] MVI_ENTRY_LAST   = 4'(MVI_ENTRY_CYCLES - 1);

  localparam logic [1:0] MVI_RESP_OKAY   = 2'h0;
  localparam logic [1:0] MVI_RESP_SLVERR = 2'h2;

  // factor flags in one carrier
  typedef struct packed {
    logic timer_slow_tick_flag;
    logic timer_mid_tick_flag;
    logic timer_fast_tick_flag;
    logic stopwatch_second_flag;
    logic stopwatch_tenth_flag;
    logic serial_done_flag;
    logic port_group0_flag;
    logic port_group1_flag;
    logic port_group2_flag;
  } mvi_flags_t;

  localparam int MVI_NFLAGS = $bits(mvi_flags_t);

  typedef enum logic [0:0] {MVI_IDLE, MVI_ENTRY} mvi_state_t;

endpackage

// ---- mvi_sticky_flags.sv ----
`timescale 1ns/100ps
module mvi_sticky_flags
  import mvi_pkg::*;
#(
  parameter int W = MVI_NFLAGS
) (
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] flags
);
  logic [W-1:0] flags_r;
  logic [W-1:0] flags_nxt;

  always_comb begin
    flags_nxt = (flags_r & ~clr) | set;
    flags     = flags_r;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end
endmodule // mvi_sticky_flags
